// >>> spl_pkg.sv
// Shared constants for the sector protection and lock control block
`default_nettype none
package spl_pkg;
  // Command opcodes
  localparam logic [7:0] OP_READ_PROT = 8'h3C;
  localparam logic [7:0] OP_PROTECT = 8'h36;
  localparam logic [7:0] OP_UNPROTECT = 8'h39;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  // Repeating answer bytes of a protection read
  localparam logic [7:0] PROT_BYTE_SET = 8'hFF;
  localparam logic [7:0] PROT_BYTE_CLR = 8'h00;
  // Status byte field positions
  localparam int SR_LOCK_POS = 7;
  localparam int SR_WP_POS = 4;
  localparam int SR_PSTAT_LSB = 2;
  localparam int SR_GLOBAL_LSB = 2;
  // Global protect and unprotect codes in bits five to two
  localparam logic [3:0] GLOBAL_UNPROTECT = 4'h0;
  localparam logic [3:0] GLOBAL_PROTECT = 4'hF;
  // Software protection status codes
  localparam logic [1:0] PSTAT_NONE = 2'h0;
  localparam logic [1:0] PSTAT_SOME = 2'h1;
  localparam logic [1:0] PSTAT_ALL = 2'h3;
  // Values after reset (power-up)
  localparam logic LOCK_RESET = 1'b0;
  localparam logic PROT_RESET = 1'b1;
  // Frame counts
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
  // Sector geometry defaults
  localparam int SECTOR_COUNT = 128;
  localparam int SECTOR_SHIFT = 16;
  // State encoding of the frame decoder
  typedef enum logic [2:0] {
    SPL_CMD = 3'b000,
    SPL_ADDR = 3'b001,
    SPL_WSR = 3'b010,
    SPL_OUT = 3'b011,
    SPL_DONE = 3'b100
  } spl_state_t;
endpackage
`default_nettype wire

// >>> spl_sync.sv
// Two-flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ns
`default_nettype none
module spl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= INIT;
      q_out <= INIT;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> spl_sector_protect_lock.sv
// Sector protection readout and lock gating on the serial command port
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - After the last address byte, output repeats FFh if protected, else 00h.
// - Chip select high ends the read at once and releases serial output.
// - Protection read shows only the stored bit, never the pin level.
// - Status field reports all, some or none sectors protected.
// - Write-protect pin never changes sector protection directly.
// - Hardware lock is active when pin is low and lock bit is one.
// - Under hardware lock, protect, unprotect and status writes are ignored.
// - To unlock, raise pin, then clear lock bit without global operation.
// - With pin low, a set lock bit clears only by power-up; all sectors protected.
// - With pin high, lock bit may be set; it then blocks sector commands.
// - Setting the lock bit also applies the global code of that write.
// - Sector protection bit alone decides protected or unprotected.
// - Soft-locked bit may be cleared; global operations need a later write.
// - With lock bit zero, setting it and all protection operations are allowed.
// - Unlocked status writes 7Fh or 00h protect or unprotect all, lock unchanged.
// - Only bit seven of a status write is stored; bits four to two read status.
module spl_sector_protect_lock
  import spl_pkg::*;
#(
  parameter int SECTORS = spl_pkg::SECTOR_COUNT,
  parameter int SEC_SHIFT = spl_pkg::SECTOR_SHIFT
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out,
  output logic protection_regs_locked_out,
  output logic hw_lock_out,
  output logic [1:0] software_protection_status_out
);
  import spl_pkg::*;
  localparam int SEC_BITS = $clog2(SECTORS);

  // Refuse geometries the sector index cannot cover exactly
  if (SECTORS < 2 || SECTORS != (1 << SEC_BITS) || SEC_SHIFT + SEC_BITS > 24) begin : g_bad_geometry
    $error("Sector geometry does not fit a 24-bit address");
  end

  // Sector index taken from a full byte address
  function automatic logic [SEC_BITS-1:0] sector_of(input logic [23:0] a);
    sector_of = a[SEC_SHIFT +: SEC_BITS];
  endfunction

  logic rst_sync;
  logic [3:0] pins_s;
  logic sck_s, cs_n_s, si_s, wp_n_s;
  logic sck_d;

  // Reset release through two flip-flops
  spl_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(1'b1),
    .q_out(rst_sync)
  );

  // Pin inputs through two flip-flops
  spl_sync #(.WIDTH(4), .INIT(4'h9)) u_pin_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_sync),
    .d_in({cs_n_in, sck_in, si_in, wp_n_in}),
    .q_out(pins_s)
  );
  assign {cs_n_s, sck_s, si_s, wp_n_s} = pins_s;

  spl_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [1:0] addr_cnt, next_addr_cnt;
  logic [6:0] shift_in, next_shift_in;
  logic [7:0] opcode, next_opcode;
  logic [15:0] addr_hi, next_addr_hi;
  logic [7:0] out_sh, next_out_sh;
  logic next_so, next_so_oe;
  logic lock, next_lock;
  logic [SECTORS-1:0] prot, next_prot;
  logic [1:0] next_pstat;
  logic next_hw_lock;

  logic sck_rise, sck_fall, hw_lock;
  logic [7:0] in_byte, status_byte;
  logic [23:0] full_addr;
  logic [SEC_BITS-1:0] sec;

  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign in_byte = {shift_in, si_s};
  assign full_addr = {addr_hi, in_byte};
  assign sec = sector_of(full_addr);
  assign hw_lock = ~wp_n_s & lock;

  // Status byte; bits four to two show pin and protection state
  always_comb begin
    status_byte = 8'h00;
    // only the lock bit is stored
    status_byte[SR_LOCK_POS] = lock;
    status_byte[SR_WP_POS] = wp_n_s;
    status_byte[SR_PSTAT_LSB +: 2] = software_protection_status_out;
  end

  // Frame decoder, protection store and output shifter
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_addr_cnt = addr_cnt;
    next_shift_in = shift_in;
    next_opcode = opcode;
    next_addr_hi = addr_hi;
    next_out_sh = out_sh;
    next_so = so_out;
    next_so_oe = so_oe_out;
    next_lock = lock;
    next_prot = prot;
    if (cs_n_s) begin
      // chip select high ends the frame and releases output
      next_state = SPL_CMD;
      next_bit_cnt = 3'h0;
      next_addr_cnt = 2'h0;
      next_so_oe = 1'b0;
      next_so = 1'b0;
    end else if (sck_rise) begin
      // sample on rising edge, MSB first
      next_shift_in = in_byte[6:0];
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == LAST_BIT) begin
        unique case (state)
          SPL_CMD: begin
            next_opcode = in_byte;
            if (in_byte == OP_READ_PROT || in_byte == OP_PROTECT || in_byte == OP_UNPROTECT) begin
              next_state = SPL_ADDR;
            end else if (in_byte == OP_WRITE_STATUS) begin
              next_state = SPL_WSR;
            end else if (in_byte == OP_READ_STATUS) begin
              next_out_sh = status_byte;
              next_state = SPL_OUT;
            end else begin
              next_state = SPL_DONE;
            end
          end
          SPL_ADDR: begin
            next_addr_hi = {addr_hi[7:0], in_byte};
            next_addr_cnt = addr_cnt + 2'h1;
            if (addr_cnt == LAST_ADDR_BYTE) begin
              if (opcode == OP_READ_PROT) begin
                // answer byte from the stored bit
                // pin level plays no part here
                next_out_sh = prot[sec] ? PROT_BYTE_SET : PROT_BYTE_CLR;
                next_state = SPL_OUT;
              end else begin
                // a set lock bit blocks sector commands
                if (!lock) begin
                  next_prot[sec] = (opcode == OP_PROTECT);
                end
                next_state = SPL_DONE;
              end
            end
          end
          SPL_WSR: begin
            // status write ignored under hardware lock
            if (!hw_lock) begin
              // with pin low, a set bit cannot be cleared here
              // soft lock may be cleared, no global this time
              next_lock = in_byte[SR_LOCK_POS];
              // global code applies when setting the lock
              // lock bit unchanged by 7Fh and 00h only while it is zero
              if (!lock) begin
                if (in_byte[SR_GLOBAL_LSB +: 4] == GLOBAL_PROTECT) begin
                  next_prot = '1;
                end else if (in_byte[SR_GLOBAL_LSB +: 4] == GLOBAL_UNPROTECT) begin
                  next_prot = '0;
                end
              end
            end
            next_state = SPL_DONE;
          end
          SPL_OUT: next_state = SPL_OUT;
          SPL_DONE: next_state = SPL_DONE;
          default: next_state = SPL_DONE;
        endcase
      end
    end else if (sck_fall && state == SPL_OUT) begin
      // drive on falling edge; byte repeats by rotation
      next_so = out_sh[7];
      next_so_oe = 1'b1;
      next_out_sh = {out_sh[6:0], out_sh[7]};
    end
  end

  // all, some or none of the sectors protected
  always_comb begin
    if (&next_prot) begin
      next_pstat = PSTAT_ALL;
    end else if (|next_prot) begin
      next_pstat = PSTAT_SOME;
    end else begin
      next_pstat = PSTAT_NONE;
    end
    next_hw_lock = ~wp_n_s & next_lock;
  end

  // State registers; power-up protects every sector, lock clear
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= SPL_CMD;
      bit_cnt <= 3'h0;
      addr_cnt <= 2'h0;
      shift_in <= 7'h00;
      opcode <= 8'h00;
      addr_hi <= 16'h0000;
      out_sh <= 8'h00;
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
      lock <= LOCK_RESET;
      prot <= {SECTORS{PROT_RESET}};
      sck_d <= 1'b0;
      software_protection_status_out <= PSTAT_ALL;
      protection_regs_locked_out <= LOCK_RESET;
      hw_lock_out <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      addr_cnt <= next_addr_cnt;
      shift_in <= next_shift_in;
      opcode <= next_opcode;
      addr_hi <= next_addr_hi;
      out_sh <= next_out_sh;
      so_out <= next_so;
      so_oe_out <= next_so_oe;
      lock <= next_lock;
      prot <= next_prot;
      sck_d <= sck_s;
      software_protection_status_out <= next_pstat;
      protection_regs_locked_out <= next_lock;
      hw_lock_out <= next_hw_lock;
    end
  end
endmodule
`default_nettype wire

// >>> spl_checker_sva.sv
// Port-level checks of the sector protection block
`timescale 1ns/1ns
`default_nettype none
module spl_checker #(
  parameter int SECTORS = 128,
  parameter int SEC_SHIFT = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  input wire logic so_out,
  input wire logic so_oe_out,
  input wire logic protection_regs_locked_out,
  input wire logic hw_lock_out,
  input wire logic [1:0] software_protection_status_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Steps that lead up to a checked outcome
  sequence s_desel; cs_n_in [*6]; endsequence
  sequence s_hw_req; (!wp_n_in && protection_regs_locked_out) [*6]; endsequence
  // Serial output behaviour
  property p_release; s_desel |-> !so_oe_out; endproperty
  property p_so_idle; !so_oe_out |-> !so_out; endproperty
  property p_so_edge; so_oe_out && $changed(so_out) |-> !sck_in; endproperty
  property p_oe_start; $rose(so_oe_out) |-> !cs_n_in && !sck_in; endproperty
  // Locking behaviour
  property p_hw_on; s_hw_req |-> hw_lock_out; endproperty
  property p_hw_off; wp_n_in [*6] |-> !hw_lock_out; endproperty
  property p_hw_bit; hw_lock_out |-> protection_regs_locked_out; endproperty
  property p_lock_fall; $fell(protection_regs_locked_out) |-> $past(wp_n_in, 3); endproperty
  property p_frozen; hw_lock_out && $past(hw_lock_out) |-> $stable(software_protection_status_out); endproperty
  a_release: assert property (p_release) else $error("so enabled while deselected");
  a_so_idle: assert property (p_so_idle) else $error("so high while released");
  a_so_edge: assert property (p_so_edge) else $error("so moved while sck high");
  a_oe_start: assert property (p_oe_start) else $error("so enabled outside frame");
  a_hw_on: assert property (p_hw_on) else $error("hw lock missing");
  a_hw_off: assert property (p_hw_off) else $error("hw lock with pin high");
  a_hw_bit: assert property (p_hw_bit) else $error("hw lock without lock bit");
  a_lock_fall: assert property (p_lock_fall) else $error("lock cleared with pin low");
  a_frozen: assert property (p_frozen) else $error("status moved under hw lock");
endmodule
bind spl_sector_protect_lock spl_checker #(.SECTORS(SECTORS), .SEC_SHIFT(SEC_SHIFT)) u_chk (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in), .wp_n_in(wp_n_in), .so_out(so_out),
  .so_oe_out(so_oe_out), .protection_regs_locked_out(protection_regs_locked_out), .hw_lock_out(hw_lock_out),
  .software_protection_status_out(software_protection_status_out));
`default_nettype wire

// >>> spl_host_model.sv
// Behavioural host controller that frames serial commands
`timescale 1ns/1ns
`default_nettype none
module spl_host_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  // Idle bus: deselected, clock parked low
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, input int nbit, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbit; i--) begin
      si_out = tx[i];
      #62;
      sck_out = 1'b1;
      rx[i] = so_oe_in ? so_in : ~tx[i];
      #63;
      sck_out = 1'b0;
    end
  endtask
  // opcode, address, one command per frame; up to two bytes read
  task automatic frame(input logic [31:0] tx, input int nb, input int nrd, output logic [15:0] rx);
    logic [7:0] b;
    rx = 16'h0000;
    cs_n_out = 1'b0;
    #40;
    for (int k = 3; k > 3 - nb; k--) xfer(tx[k*8 +: 8], 8, b);
    for (int k = 1; k > 1 - nrd; k--) begin
      xfer(8'h00, 8, b);
      rx[k*8 +: 8] = b;
    end
    #40;
    cs_n_out = 1'b1;
    si_out = ~si_out;
    #100;
  endtask
  // Protection read cut short three bits into the answer
  task automatic cut_read(input logic [31:0] tx, output logic mid_oe);
    logic [7:0] b;
    cs_n_out = 1'b0;
    #40;
    for (int k = 3; k >= 0; k--) xfer(tx[k*8 +: 8], 8, b);
    xfer(8'h00, 3, b);
    mid_oe = so_oe_in;
    cs_n_out = 1'b1;
    si_out = ~si_out;
  endtask
endmodule
`default_nettype wire

// >>> spl_sector_protect_lock_tb.sv
// Self-checking bench of the sector protection block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module spl_sector_protect_lock_tb;
  import spl_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic [15:0] rd;
  logic oe_mid;
  int err_total = 0;
  int samples_checked = 0;
  wire logic sck, cs_n, si, so, so_oe, lock, hw;
  wire logic [1:0] pstat;
  // System clock
  always #5 clk_in = ~clk_in;
  spl_sector_protect_lock u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe), .protection_regs_locked_out(lock), .hw_lock_out(hw),
    .software_protection_status_out(pstat));
  spl_host_model u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Command helpers
  task automatic wsr(input logic [7:0] d);
    u_host.frame({OP_WRITE_STATUS, d, 16'h0000}, 2, 0, rd);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    u_host.frame({op, a}, 4, 0, rd);
  endtask
  task automatic rdp(input logic [23:0] a, input logic [7:0] e);
    u_host.frame({OP_READ_PROT, a}, 4, 2, rd);
    `CHK(rd[15:8], e)
    `CHK(rd[7:0], e)
  endtask
  task automatic rds(input logic [7:0] e);
    u_host.frame({OP_READ_STATUS, 24'h00_0000}, 1, 2, rd);
    `CHK(rd[15:8], e)
    `CHK(rd[7:0], e)
  endtask
  task automatic st(input logic l, input logic [1:0] s);
    `CHK(lock, l)
    `CHK(pstat, s)
  endtask
  task automatic set_wp(input logic v);
    @(posedge clk_in);
    #1 wp_n_in = v;
    #100;
  endtask
  task automatic pwr_cycle();
    @(posedge clk_in);
    #1 rst_n_in = 1'b0;
    repeat (12) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    #200;
  endtask
  // Scenarios
  task automatic t_power_up();
    st(1'b0, PSTAT_ALL);
    `CHK(so_oe, 1'b0)
    rdp(24'h05_1234, PROT_BYTE_SET);
    rds(8'h1C);
  endtask
  task automatic t_global();
    wsr(8'h00);
    st(1'b0, PSTAT_NONE);
    rdp(24'h7F_FFFF, PROT_BYTE_CLR);
    wsr(8'h7F);
    st(1'b0, PSTAT_ALL);
  endtask
  task automatic t_sector();
    cmd(OP_UNPROTECT, 24'h03_8000);
    st(1'b0, PSTAT_SOME);
    rdp(24'h03_0000, PROT_BYTE_CLR);
    rdp(24'h04_0000, PROT_BYTE_SET);
    cmd(OP_PROTECT, 24'h03_FFFF);
    st(1'b0, PSTAT_ALL);
  endtask
  task automatic t_soft();
    wsr(8'h80);
    st(1'b1, PSTAT_NONE);
    cmd(OP_PROTECT, 24'h01_0000);
    st(1'b1, PSTAT_NONE);
    wsr(8'h7F);
    st(1'b0, PSTAT_NONE);
    wsr(8'hBC);
    st(1'b1, PSTAT_ALL);
  endtask
  task automatic t_hw();
    set_wp(1'b0);
    `CHK(hw, 1'b1)
    st(1'b1, PSTAT_ALL);
    rds(8'h8C);
    wsr(8'h00);
    st(1'b1, PSTAT_ALL);
    cmd(OP_UNPROTECT, 24'h02_0000);
    st(1'b1, PSTAT_ALL);
    rdp(24'h02_0000, PROT_BYTE_SET);
    set_wp(1'b1);
    `CHK(hw, 1'b0)
    wsr(8'h0F);
    st(1'b0, PSTAT_ALL);
    set_wp(1'b0);
    wsr(8'h00);
    st(1'b0, PSTAT_NONE);
    wsr(8'hFF);
    wsr(8'h0F);
    st(1'b1, PSTAT_ALL);
    pwr_cycle();
    st(1'b0, PSTAT_ALL);
    set_wp(1'b1);
  endtask
  task automatic t_abort();
    u_host.cut_read({OP_READ_PROT, 24'h00_0000}, oe_mid);
    `CHK(oe_mid, 1'b1)
    repeat (8) @(posedge clk_in);
    #1;
    `CHK(so_oe, 1'b0)
    `CHK(so, 1'b0)
    #100;
  endtask
  // Reset, scenarios, verdict
  initial begin
    repeat (12) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    #200;
    t_power_up();
    t_global();
    t_sector();
    t_soft();
    t_hw();
    t_abort();
    end_of_test();
  end
  // Watchdog against a hung frame
  initial begin
    #900000;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
